/* hw/mksm_pkg.sv */
// Package: constants and types for the MAC security key state manager
package mksm_pkg;
  localparam int KEY_W = 128;
  localparam int LVL_W = 2;
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_ONE = 2'h1;
  localparam logic [1:0] LVL_TWO = 2'h2;
  // Frame protection classes
  localparam logic [1:0] PROT_PLAIN = 2'h0;
  localparam logic [1:0] PROT_AUTH = 2'h1;
  localparam logic [1:0] PROT_AUTH_ENC = 2'h2;
  // Key roles handed to the derivation engine
  localparam logic [1:0] DRV_WRAP = 2'h0;
  localparam logic [1:0] DRV_JOIN = 2'h1;
  // Connection kinds
  localparam logic [1:0] CONN_UNI = 2'h0;
  localparam logic [1:0] CONN_MULTI = 2'h1;
  localparam logic [1:0] CONN_BCAST = 2'h2;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_PERIOD = 4'h2;
  localparam logic [3:0] REG_LEVEL = 4'h3;
  // Timing
  localparam longint CLK_HZ = 125000000;
  localparam longint GROUP_HOLD_S = 10800; // 3 hours
  localparam longint GROUP_HOLD_CYC = GROUP_HOLD_S * CLK_HZ;
  localparam logic [31:0] PERIOD_RST = 32'h0000_ffff;
  typedef enum logic [3:0] {
    MKSM_DISC = 4'h1,
    MKSM_JOINING = 4'h2,
    MKSM_JOINED = 4'h4,
    MKSM_CONFIRM = 4'h8
  } mksm_state_t;
endpackage

/* hw/mksm_core.sv */
// Security key state manager: join level, key slots, refresh timers, frame protection
`timescale 1ns/1ps
// Behaviour
// - Join offers one level; reply echoes it, gives 0/1/2, or rejects.
// - One negotiated level applies to all traffic and connections of the node.
// - Unique 128-bit root key used only to derive other keys.
// - Wrap key derived from root key with subnet address; used only to unwrap.
// - Join auth key derived likewise; protects join messages only when not rejoining.
// - Missing refresh within period returns node to disconnected.
// - Join response with unwrap failure is discarded; joining continues.
// - New unicast key used for transmit immediately on receipt.
// - Old and new unicast keys both accepted until exchange completes.
// - Unicast unwrap failure reported; old key kept.
// - New group key used only after frame with it arrives or 3 hours pass.
// - Group unwrap failure reported; old group key kept.
// - Plain frames bypass CCM; no tag appended or checked.
// - Auth-only frames feed masked header, subheader, payload all as associated data.
// - Auth-encrypt frames feed headers as associated data, payload as CCM payload.
// - Levels 1 and 2: data plain only if both sides decline security.
// - Broadcast always secured (here plain at level 0 and for level-1 control frames); multicast upgrades on secured receipt, never downgrades.
module mksm_core #(
  parameter longint GROUP_HOLD = mksm_pkg::GROUP_HOLD_CYC,
  parameter int     NCONN      = 8
) (
  input  wire logic                       mclk,
  input  wire logic                       srst,
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  input  wire logic [mksm_pkg::KEY_W-1:0] root_key_attribute,
  input  wire logic [39:0]                subnet_address,
  output logic      [1:0]                 drv_role,
  output logic      [mksm_pkg::KEY_W-1:0] drv_key,
  output logic      [39:0]                drv_context,
  input  wire logic                       join_response,
  input  wire logic                       join_reject,
  input  wire logic [1:0]                 rsp_level,
  input  wire logic                       rejoin_flag,
  output logic                            join_use_auth_key,
  input  wire logic                       key_refresh_msg,
  input  wire logic                       uni_present,
  input  wire logic                       grp_present,
  input  wire logic                       uni_unwrap_ok,
  input  wire logic                       grp_unwrap_ok,
  input  wire logic [mksm_pkg::KEY_W-1:0] uni_key_in,
  input  wire logic [mksm_pkg::KEY_W-1:0] grp_key_in,
  input  wire logic                       refresh_done,
  input  wire logic                       rx_grp_new,
  output logic                            uni_fail,
  output logic                            grp_fail,
  output logic      [mksm_pkg::KEY_W-1:0] uni_tx_key,
  output logic      [mksm_pkg::KEY_W-1:0] uni_old_key,
  output logic                            uni_old_ok,
  output logic      [mksm_pkg::KEY_W-1:0] grp_tx_key,
  output logic      [mksm_pkg::KEY_W-1:0] grp_new_key,
  output logic                            grp_new_ok,
  input  wire logic                       conn_set,
  input  wire logic [$clog2(NCONN)-1:0]   conn_id,
  input  wire logic [1:0]                 conn_kind,
  input  wire logic                       conn_local_sec,
  input  wire logic                       conn_peer_sec,
  input  wire logic                       rx_secured,
  input  wire logic                       frm_req,
  input  wire logic                       frm_ctrl,
  output logic      [1:0]                 frm_prot,
  output logic                            frm_mask_fields,
  output logic                            frm_payload_enc,
  output logic      [1:0]                 link_state
);
  // Key state
  mksm_pkg::mksm_state_t st_ff, nxt_st;
  logic [1:0]  lvl_ff, nxt_lvl, offer_ff, nxt_offer;
  logic [31:0] period_ff, nxt_period, ref_cnt_ff, nxt_ref_cnt;
  logic [63:0] grp_cnt_ff, nxt_grp_cnt;
  logic [mksm_pkg::KEY_W-1:0] uni_cur_ff, nxt_uni_cur, uni_old_ff, nxt_uni_old;
  logic [mksm_pkg::KEY_W-1:0] grp_cur_ff, nxt_grp_cur, grp_new_ff, nxt_grp_new;
  logic uni_old_v_ff, nxt_uni_old_v, grp_new_v_ff, nxt_grp_new_v;
  logic uni_fail_ff, nxt_uni_fail, grp_fail_ff, nxt_grp_fail;
  logic join_go_ff, nxt_join_go, timeout_ff, nxt_timeout;
  logic [NCONN-1:0] sec_ff, nxt_sec, bc_ff, nxt_bc;
  logic [1:0] prot_ff, nxt_prot;
  logic [31:0] rdata_ff, nxt_rdata;

  // Level 0 never secures anything
  function automatic logic lvl_secure(input logic [1:0] l);
    return (l == mksm_pkg::LVL_ONE) || (l == mksm_pkg::LVL_TWO);
  endfunction

  // Root key only feeds derivation; context is the subnet address
  assign drv_key = root_key_attribute;
  assign drv_context = subnet_address;
  assign drv_role = (st_ff == mksm_pkg::MKSM_JOINING) ? mksm_pkg::DRV_JOIN
                                                      : mksm_pkg::DRV_WRAP;
  assign join_use_auth_key = lvl_secure(offer_ff) && !rejoin_flag;

  // Join, refresh and key slot next state
  always_comb begin
    nxt_st = st_ff;
    nxt_lvl = lvl_ff;
    nxt_offer = offer_ff;
    nxt_period = period_ff;
    nxt_ref_cnt = ref_cnt_ff;
    nxt_grp_cnt = grp_cnt_ff;
    nxt_uni_cur = uni_cur_ff;
    nxt_uni_old = uni_old_ff;
    nxt_uni_old_v = uni_old_v_ff;
    nxt_grp_cur = grp_cur_ff;
    nxt_grp_new = grp_new_ff;
    nxt_grp_new_v = grp_new_v_ff;
    nxt_uni_fail = uni_fail_ff;
    nxt_grp_fail = grp_fail_ff;
    nxt_join_go = 1'b0;
    nxt_timeout = timeout_ff;
    // Software control
    if (reg_wr && reg_addr == mksm_pkg::REG_CTRL) begin
      nxt_offer = reg_wdata[1:0];
      nxt_join_go = reg_wdata[4];
      if (reg_wdata[8]) nxt_uni_fail = 1'b0;
      if (reg_wdata[9]) nxt_grp_fail = 1'b0;
      if (reg_wdata[10]) nxt_timeout = 1'b0;
    end
    if (reg_wr && reg_addr == mksm_pkg::REG_PERIOD) nxt_period = reg_wdata;
    case (st_ff)
      mksm_pkg::MKSM_DISC: begin
        if (join_go_ff) nxt_st = mksm_pkg::MKSM_JOINING;
      end
      mksm_pkg::MKSM_JOINING: begin
        if (join_reject) begin
          nxt_st = mksm_pkg::MKSM_DISC;
        end else if (join_response && uni_unwrap_ok && grp_unwrap_ok) begin
          nxt_st = mksm_pkg::MKSM_CONFIRM;
          nxt_lvl = rsp_level;
          nxt_uni_cur = uni_key_in;
          nxt_grp_cur = grp_key_in;
          nxt_uni_old_v = 1'b0;
          nxt_grp_new_v = 1'b0;
          nxt_ref_cnt = 32'h0;
        end
        // Failed unwrap: response dropped, stay joining
      end
      mksm_pkg::MKSM_CONFIRM: begin
        // Software decides whether a weaker level is acceptable
        if (join_go_ff) nxt_st = mksm_pkg::MKSM_JOINED;
        else if (reg_wr && reg_addr == mksm_pkg::REG_CTRL && reg_wdata[5])
          nxt_st = mksm_pkg::MKSM_DISC;
      end
      mksm_pkg::MKSM_JOINED: begin
        nxt_ref_cnt = ref_cnt_ff + 32'h1;
        if (key_refresh_msg) nxt_ref_cnt = 32'h0;
        if (!key_refresh_msg && ref_cnt_ff >= period_ff) begin
          nxt_st = mksm_pkg::MKSM_DISC;
          nxt_timeout = 1'b1;
          // Pending key slots die with the link, so a rejoin starts clean
          nxt_uni_old_v = 1'b0;
          nxt_grp_new_v = 1'b0;
        end
        if (key_refresh_msg && uni_present) begin
          if (uni_unwrap_ok) begin
            nxt_uni_old = uni_cur_ff;
            nxt_uni_old_v = 1'b1;
            nxt_uni_cur = uni_key_in;
          end else begin
            nxt_uni_fail = 1'b1;
          end
        end else if (refresh_done) begin
          nxt_uni_old_v = 1'b0;
        end
        if (key_refresh_msg && grp_present) begin
          if (grp_unwrap_ok) begin
            nxt_grp_new = grp_key_in;
            nxt_grp_new_v = 1'b1;
            nxt_grp_cnt = 64'h0;
          end else begin
            nxt_grp_fail = 1'b1;
          end
        end else if (grp_new_v_ff) begin
          nxt_grp_cnt = grp_cnt_ff + 64'h1;
          if (rx_grp_new || grp_cnt_ff >= 64'(GROUP_HOLD - 1)) begin
            nxt_grp_cur = grp_new_ff;
            nxt_grp_new_v = 1'b0;
          end
        end
      end
      default: nxt_st = mksm_pkg::MKSM_DISC;
    endcase
  end

  // Key state registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= mksm_pkg::MKSM_DISC;
      lvl_ff <= mksm_pkg::LVL_NONE;
      offer_ff <= mksm_pkg::LVL_TWO;
      period_ff <= mksm_pkg::PERIOD_RST;
      ref_cnt_ff <= 32'h0;
      grp_cnt_ff <= 64'h0;
      uni_cur_ff <= '0;
      uni_old_ff <= '0;
      uni_old_v_ff <= 1'b0;
      grp_cur_ff <= '0;
      grp_new_ff <= '0;
      grp_new_v_ff <= 1'b0;
      uni_fail_ff <= 1'b0;
      grp_fail_ff <= 1'b0;
      join_go_ff <= 1'b0;
      timeout_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      lvl_ff <= nxt_lvl;
      offer_ff <= nxt_offer;
      period_ff <= nxt_period;
      ref_cnt_ff <= nxt_ref_cnt;
      grp_cnt_ff <= nxt_grp_cnt;
      uni_cur_ff <= nxt_uni_cur;
      uni_old_ff <= nxt_uni_old;
      uni_old_v_ff <= nxt_uni_old_v;
      grp_cur_ff <= nxt_grp_cur;
      grp_new_ff <= nxt_grp_new;
      grp_new_v_ff <= nxt_grp_new_v;
      uni_fail_ff <= nxt_uni_fail;
      grp_fail_ff <= nxt_grp_fail;
      join_go_ff <= nxt_join_go;
      timeout_ff <= nxt_timeout;
    end
  end

  assign uni_tx_key = uni_cur_ff;
  assign uni_old_key = uni_old_ff;
  assign uni_old_ok = uni_old_v_ff;
  assign grp_tx_key = grp_cur_ff;
  assign grp_new_key = grp_new_ff;
  assign grp_new_ok = grp_new_v_ff;
  assign uni_fail = uni_fail_ff;
  assign grp_fail = grp_fail_ff;
  assign link_state = {st_ff == mksm_pkg::MKSM_JOINED, st_ff == mksm_pkg::MKSM_CONFIRM};

  // Per-connection security table and frame classing
  always_comb begin
    nxt_sec = sec_ff;
    nxt_bc = bc_ff;
    nxt_prot = prot_ff;
    if (conn_set) begin
      nxt_bc[conn_id] = (conn_kind == mksm_pkg::CONN_BCAST);
      nxt_sec[conn_id] = (conn_kind == mksm_pkg::CONN_BCAST)
                         || conn_local_sec || conn_peer_sec;
    end else if (rx_secured && frm_req) begin
      nxt_sec[conn_id] = 1'b1;
    end
    if (frm_req) begin
      if (!lvl_secure(lvl_ff)) nxt_prot = mksm_pkg::PROT_PLAIN;
      else if (frm_ctrl) nxt_prot = (lvl_ff == mksm_pkg::LVL_TWO) ? mksm_pkg::PROT_AUTH_ENC
                                                                   : mksm_pkg::PROT_PLAIN;
      // A secured frame is handled secured before its upgrade lands in the table
      else if (sec_ff[conn_id] || bc_ff[conn_id] || rx_secured)
        nxt_prot = mksm_pkg::PROT_AUTH_ENC;
      else nxt_prot = mksm_pkg::PROT_PLAIN;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sec_ff <= '0;
      bc_ff <= '0;
      prot_ff <= mksm_pkg::PROT_PLAIN;
    end else begin
      sec_ff <= nxt_sec;
      bc_ff <= nxt_bc;
      prot_ff <= nxt_prot;
    end
  end

  // Plain bypasses CCM; masked fields only under CCM
  assign frm_prot = prot_ff;
  assign frm_mask_fields = (prot_ff != mksm_pkg::PROT_PLAIN);
  assign frm_payload_enc = (prot_ff == mksm_pkg::PROT_AUTH_ENC);

  // Register read
  always_comb begin
    nxt_rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        mksm_pkg::REG_CTRL: nxt_rdata = {30'h0, offer_ff};
        mksm_pkg::REG_STATUS: nxt_rdata = {21'h0, timeout_ff, grp_fail_ff, uni_fail_ff,
                                           grp_new_v_ff, uni_old_v_ff, 2'h0, st_ff};
        mksm_pkg::REG_PERIOD: nxt_rdata = period_ff;
        mksm_pkg::REG_LEVEL: nxt_rdata = {30'h0, lvl_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) rdata_ff <= 32'h0;
    else rdata_ff <= nxt_rdata;
  end
  assign reg_rdata = rdata_ff;

  // Checks
  property p_refresh_timeout;
    @(posedge mclk) disable iff (srst)
      (st_ff == mksm_pkg::MKSM_JOINED && !key_refresh_msg && ref_cnt_ff >= period_ff)
      |=> st_ff == mksm_pkg::MKSM_DISC;
  endproperty
  a_refresh_timeout: assert property (p_refresh_timeout) else $error("no timeout");
  property p_bad_join;
    @(posedge mclk) disable iff (srst)
      (st_ff == mksm_pkg::MKSM_JOINING && join_response && !join_reject && !uni_unwrap_ok)
      |=> st_ff == mksm_pkg::MKSM_JOINING;
  endproperty
  a_bad_join: assert property (p_bad_join) else $error("bad join accepted");
  property p_uni_switch;
    @(posedge mclk) disable iff (srst)
      (st_ff == mksm_pkg::MKSM_JOINED && key_refresh_msg && uni_present && uni_unwrap_ok)
      |=> uni_tx_key == $past(uni_key_in) && uni_old_ok;
  endproperty
  a_uni_switch: assert property (p_uni_switch) else $error("unicast key not switched");
  property p_uni_fail;
    @(posedge mclk) disable iff (srst)
      (st_ff == mksm_pkg::MKSM_JOINED && key_refresh_msg && uni_present && !uni_unwrap_ok)
      |=> uni_fail && $stable(uni_tx_key);
  endproperty
  a_uni_fail: assert property (p_uni_fail) else $error("unicast failure mishandled");
  property p_grp_hold;
    @(posedge mclk) disable iff (srst)
      (grp_new_ok && !rx_grp_new && !key_refresh_msg && grp_cnt_ff < 64'(GROUP_HOLD - 1))
      |=> $stable(grp_tx_key);
  endproperty
  a_grp_hold: assert property (p_grp_hold) else $error("group key switched early");
  property p_grp_fail;
    @(posedge mclk) disable iff (srst)
      (st_ff == mksm_pkg::MKSM_JOINED && key_refresh_msg && grp_present && !grp_unwrap_ok)
      |=> grp_fail && $stable(grp_tx_key);
  endproperty
  a_grp_fail: assert property (p_grp_fail) else $error("group failure mishandled");
  property p_plain;
    @(posedge mclk) disable iff (srst)
      frm_req && !lvl_secure(lvl_ff) |=> frm_prot == mksm_pkg::PROT_PLAIN && !frm_mask_fields;
  endproperty
  a_plain: assert property (p_plain) else $error("level 0 frame protected");
  property p_bcast;
    @(posedge mclk) disable iff (srst)
      conn_set && conn_kind == mksm_pkg::CONN_BCAST |=> sec_ff[$past(conn_id)];
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not secured");
  c_join: cover property (@(posedge mclk) st_ff == mksm_pkg::MKSM_JOINED);
  c_grp_swap: cover property (@(posedge mclk) grp_new_ok && rx_grp_new);
  c_timeout: cover property (@(posedge mclk) timeout_ff);
endmodule

/* test/mksm_peer.sv */
// Behavioural model of the remote base node that feeds the key manager
`timescale 1ns/1ps
module mksm_peer (
  input  wire logic         mclk,
  output logic              join_response,
  output logic              join_reject,
  output logic [1:0]        rsp_level,
  output logic              key_refresh_msg,
  output logic              uni_present,
  output logic              grp_present,
  output logic              uni_unwrap_ok,
  output logic              grp_unwrap_ok,
  output logic [127:0]      uni_key_in,
  output logic [127:0]      grp_key_in,
  output logic              refresh_done,
  output logic              rx_grp_new
);
  // Quiet link at time zero
  initial begin
    join_response   = 1'b0;
    join_reject     = 1'b0;
    rsp_level       = 2'h0;
    key_refresh_msg = 1'b0;
    uni_present     = 1'b0;
    grp_present     = 1'b0;
    uni_unwrap_ok   = 1'b0;
    grp_unwrap_ok   = 1'b0;
    uni_key_in      = 128'h0;
    grp_key_in      = 128'h0;
    refresh_done    = 1'b0;
    rx_grp_new      = 1'b0;
  end

  // Qualifiers go stale after a message, so never leave the last value showing
  task automatic scramble();
    rsp_level     <= ~rsp_level;
    uni_present   <= ~uni_present;
    grp_present   <= ~grp_present;
    uni_unwrap_ok <= ~uni_unwrap_ok;
    grp_unwrap_ok <= ~grp_unwrap_ok;
    uni_key_in    <= ~uni_key_in;
    grp_key_in    <= ~grp_key_in;
  endtask

  // Join answer: echoed or replaced level, fresh keys, old group key if mid-refresh
  task automatic send_join(input logic [1:0] lvl, input logic ok, input logic [127:0] uk,
                           input logic [127:0] gk);
    @(posedge mclk);
    join_response <= 1'b1;
    rsp_level     <= lvl;
    uni_unwrap_ok <= ok;
    grp_unwrap_ok <= ok;
    uni_key_in    <= uk;
    grp_key_in    <= gk;
    @(posedge mclk);
    join_response <= 1'b0;
    scramble();
  endtask

  // Key refresh; a failed unicast unwrap is answered by the bench sending again
  task automatic send_refresh(input logic up, input logic gp, input logic uok, input logic gok,
                              input logic [127:0] uk, input logic [127:0] gk);
    @(posedge mclk);
    key_refresh_msg <= 1'b1;
    uni_present     <= up;
    grp_present     <= gp;
    uni_unwrap_ok   <= uok;
    grp_unwrap_ok   <= gok;
    uni_key_in      <= uk;
    grp_key_in      <= gk;
    @(posedge mclk);
    key_refresh_msg <= 1'b0;
    scramble();
  endtask

  // Base node got the refresh response and leaves the old unicast key
  task automatic exchange_done();
    @(posedge mclk);
    refresh_done <= 1'b1;
    @(posedge mclk);
    refresh_done <= 1'b0;
  endtask

  // A frame under the new group key arrives; base node has dropped the old one
  task automatic group_seen();
    @(posedge mclk);
    rx_grp_new <= 1'b1;
    @(posedge mclk);
    rx_grp_new <= 1'b0;
  endtask
endmodule

/* test/mksm_core_tb.sv */
// Self-checking bench for the key state manager
`timescale 1ns/1ps
module mksm_core_tb;
  logic         mclk, srst, reg_wr, reg_rd, rejoin_flag, conn_set, conn_local_sec;
  logic         conn_peer_sec, rx_secured, frm_req, frm_ctrl;
  logic [3:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, rd;
  logic [127:0] root_key_attribute, uni_key_in, grp_key_in, drv_key;
  logic [127:0] uni_tx_key, uni_old_key, grp_tx_key, grp_new_key;
  logic [39:0]  subnet_address, drv_context;
  logic [2:0]   conn_id;
  logic [1:0]   conn_kind, rsp_level, drv_role, frm_prot, link_state;
  logic         join_response, join_reject, key_refresh_msg, uni_present, grp_present;
  logic         uni_unwrap_ok, grp_unwrap_ok, refresh_done, rx_grp_new, join_use_auth_key;
  logic         uni_fail, grp_fail, uni_old_ok, grp_new_ok, frm_mask_fields, frm_payload_enc;
  int           mismatches, n_compared, cyc;
  localparam logic [127:0] K1 = {4{32'h1a2b_0001}};
  localparam logic [127:0] K2 = {4{32'h1a2b_0002}};
  localparam logic [127:0] K3 = {4{32'h1a2b_0003}};
  localparam logic [127:0] G1 = {4{32'h6c5d_0001}};
  localparam logic [127:0] G2 = {4{32'h6c5d_0002}};
  localparam logic [127:0] G3 = {4{32'h6c5d_0003}};

  // Group hold cut to 20 cycles so the timer runs out inside the test
  mksm_core #(.GROUP_HOLD(20), .NCONN(8)) mksm_core_inst (.mclk, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .root_key_attribute, .subnet_address,
    .drv_role, .drv_key, .drv_context, .join_response, .join_reject, .rsp_level,
    .rejoin_flag, .join_use_auth_key, .key_refresh_msg, .uni_present, .grp_present,
    .uni_unwrap_ok, .grp_unwrap_ok, .uni_key_in, .grp_key_in, .refresh_done,
    .rx_grp_new, .uni_fail, .grp_fail, .uni_tx_key, .uni_old_key, .uni_old_ok,
    .grp_tx_key, .grp_new_key, .grp_new_ok, .conn_set, .conn_id, .conn_kind,
    .conn_local_sec, .conn_peer_sec, .rx_secured, .frm_req, .frm_ctrl, .frm_prot,
    .frm_mask_fields, .frm_payload_enc, .link_state);
  mksm_peer mksm_peer_inst (.mclk, .join_response, .join_reject, .rsp_level,
    .key_refresh_msg, .uni_present, .grp_present, .uni_unwrap_ok, .grp_unwrap_ok,
    .uni_key_in, .grp_key_in, .refresh_done, .rx_grp_new);

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compares for wide keys and for everything up to 32 bits
  task automatic chk_key(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register port: one-cycle strobes, read data in the following cycle only
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic reg_check(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    rd = reg_rdata;
    chk_val(what, exp, rd);
  endtask
  task automatic settle();
    @(posedge mclk);
    #1;
  endtask

  task automatic t_reset();
    reg_check("status", mksm_pkg::REG_STATUS, 32'h0000_0001);
    reg_check("period", mksm_pkg::REG_PERIOD, 32'h0000_ffff);
    reg_write(4'hf, 32'h0000_0055);
    reg_check("unmapped", 4'hf, 32'h0000_0000);
    reg_check("period", mksm_pkg::REG_PERIOD, 32'h0000_ffff);
    frame(3'h3, 1'b1, 1'b0, mksm_pkg::PROT_PLAIN);
    $display("test reset done");
  endtask

  task automatic t_join();
    reg_write(mksm_pkg::REG_CTRL, 32'h0000_0012);
    reg_check("status", mksm_pkg::REG_STATUS, 32'h0000_0002);
    chk_val("drv_role", {30'h0, mksm_pkg::DRV_JOIN}, {30'h0, drv_role});
    chk_val("join_use_auth_key", 32'h1, {31'h0, join_use_auth_key});
    @(posedge mclk);
    rejoin_flag <= 1'b1;
    settle();
    chk_val("join_use_auth_key", 32'h0, {31'h0, join_use_auth_key});
    @(posedge mclk);
    rejoin_flag <= 1'b0;
    chk_key("drv_key", root_key_attribute, drv_key);
    chk_val("drv_context", subnet_address[31:0], drv_context[31:0]);
    mksm_peer_inst.send_join(mksm_pkg::LVL_TWO, 1'b0, K1, G1);
    reg_check("status", mksm_pkg::REG_STATUS, 32'h0000_0002);
    mksm_peer_inst.send_join(mksm_pkg::LVL_TWO, 1'b1, K1, G1);
    reg_check("status", mksm_pkg::REG_STATUS, 32'h0000_0008);
    reg_write(mksm_pkg::REG_CTRL, 32'h0000_0012);
    reg_check("status", mksm_pkg::REG_STATUS, 32'h0000_0004);
    reg_check("level", mksm_pkg::REG_LEVEL, 32'h0000_0002);
    chk_val("link_state", 32'h2, {30'h0, link_state});
    chk_key("uni_tx_key", K1, uni_tx_key);
    chk_key("grp_tx_key", G1, grp_tx_key);
    chk_val("drv_role", {30'h0, mksm_pkg::DRV_WRAP}, {30'h0, drv_role});
    $display("test join done");
  endtask

  task automatic t_uni();
    mksm_peer_inst.send_refresh(1'b1, 1'b0, 1'b1, 1'b0, K2, G3);
    #1;
    chk_key("uni_tx_key", K2, uni_tx_key);
    chk_key("uni_old_key", K1, uni_old_key);
    chk_val("uni_old_ok", 32'h1, {31'h0, uni_old_ok});
    mksm_peer_inst.exchange_done();
    settle();
    chk_val("uni_old_ok", 32'h0, {31'h0, uni_old_ok});
    mksm_peer_inst.send_refresh(1'b1, 1'b0, 1'b0, 1'b0, K3, G3);
    settle();
    chk_val("uni_fail", 32'h1, {31'h0, uni_fail});
    chk_key("uni_tx_key", K2, uni_tx_key);
    reg_write(mksm_pkg::REG_CTRL, 32'h0000_0102);
    settle();
    chk_val("uni_fail", 32'h0, {31'h0, uni_fail});
    mksm_peer_inst.send_refresh(1'b1, 1'b0, 1'b1, 1'b0, K3, G3);
    #1;
    chk_key("uni_tx_key", K3, uni_tx_key);
    $display("test unicast done");
  endtask

  task automatic t_grp();
    mksm_peer_inst.send_refresh(1'b0, 1'b1, 1'b0, 1'b1, K1, G2);
    settle();
    chk_key("grp_tx_key", G1, grp_tx_key);
    chk_key("grp_new_key", G2, grp_new_key);
    chk_val("grp_new_ok", 32'h1, {31'h0, grp_new_ok});
    mksm_peer_inst.group_seen();
    settle();
    chk_key("grp_tx_key", G2, grp_tx_key);
    mksm_peer_inst.send_refresh(1'b0, 1'b1, 1'b0, 1'b1, K1, G3);
    repeat (19) @(posedge mclk);
    #1;
    chk_key("grp_tx_key", G2, grp_tx_key);
    settle();
    chk_key("grp_tx_key", G3, grp_tx_key);
    mksm_peer_inst.send_refresh(1'b0, 1'b1, 1'b0, 1'b0, K1, G1);
    settle();
    chk_val("grp_fail", 32'h1, {31'h0, grp_fail});
    chk_key("grp_tx_key", G3, grp_tx_key);
    $display("test group done");
  endtask

  // Connection setup and one frame request against it
  task automatic conn(input logic [2:0] id, input logic [1:0] k, input logic l, input logic p);
    @(posedge mclk);
    conn_id        <= id;
    conn_kind      <= k;
    conn_local_sec <= l;
    conn_peer_sec  <= p;
    conn_set       <= 1'b1;
    @(posedge mclk);
    conn_set       <= 1'b0;
  endtask
  task automatic frame(input logic [2:0] id, input logic c, input logic s, input logic [1:0] e);
    @(posedge mclk);
    conn_id    <= id;
    frm_ctrl   <= c;
    rx_secured <= s;
    frm_req    <= 1'b1;
    @(posedge mclk);
    frm_req    <= 1'b0;
    #1;
    chk_val("frm_prot", {30'h0, e}, {30'h0, frm_prot});
    chk_val("frm_payload_enc", {31'h0, e == mksm_pkg::PROT_AUTH_ENC}, {31'h0, frm_payload_enc});
    chk_val("frm_mask_fields", {31'h0, e != mksm_pkg::PROT_PLAIN},
            {31'h0, frm_mask_fields});
  endtask

  task automatic t_frame();
    conn(3'h0, mksm_pkg::CONN_UNI, 1'b0, 1'b0);
    conn(3'h1, mksm_pkg::CONN_UNI, 1'b1, 1'b0);
    conn(3'h2, mksm_pkg::CONN_UNI, 1'b0, 1'b1);
    conn(3'h3, mksm_pkg::CONN_BCAST, 1'b0, 1'b0);
    conn(3'h4, mksm_pkg::CONN_MULTI, 1'b0, 1'b0);
    frame(3'h0, 1'b0, 1'b0, mksm_pkg::PROT_PLAIN);
    frame(3'h1, 1'b0, 1'b0, mksm_pkg::PROT_AUTH_ENC);
    frame(3'h2, 1'b0, 1'b0, mksm_pkg::PROT_AUTH_ENC);
    frame(3'h3, 1'b0, 1'b0, mksm_pkg::PROT_AUTH_ENC);
    frame(3'h4, 1'b0, 1'b0, mksm_pkg::PROT_PLAIN);
    frame(3'h4, 1'b0, 1'b1, mksm_pkg::PROT_AUTH_ENC);
    frame(3'h4, 1'b0, 1'b0, mksm_pkg::PROT_AUTH_ENC);
    frame(3'h0, 1'b1, 1'b0, mksm_pkg::PROT_AUTH_ENC);
    $display("test frame done");
  endtask

  task automatic t_timeout();
    reg_write(mksm_pkg::REG_PERIOD, 32'h0000_0028);
    repeat (60) @(posedge mclk);
    reg_check("period", mksm_pkg::REG_PERIOD, 32'h0000_0028);
    chk_val("link_state", 32'h0, {30'h0, link_state});
    reg_check("status", mksm_pkg::REG_STATUS, 32'h0000_0601);
    reg_write(mksm_pkg::REG_CTRL, 32'h0000_0012);
    mksm_peer_inst.send_join(mksm_pkg::LVL_ONE, 1'b1, K1, G1);
    reg_check("level", mksm_pkg::REG_LEVEL, 32'h0000_0001);
    frame(3'h0, 1'b1, 1'b0, mksm_pkg::PROT_PLAIN);
    reg_write(mksm_pkg::REG_CTRL, 32'h0000_0022);
    reg_check("status", mksm_pkg::REG_STATUS, 32'h0000_0601);
    $display("test timeout done");
  endtask

  // Inputs defined at time zero, reset held five cycles
  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, rejoin_flag, conn_set, conn_local_sec} = 5'h0;
    {conn_peer_sec, rx_secured, frm_req, frm_ctrl} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    conn_id = 3'h0;
    conn_kind = 2'h0;
    root_key_attribute = {4{32'h3e9f_77c1}};
    subnet_address = 40'h12_3456_789a;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_join();
    t_uni();
    t_grp();
    t_frame();
    t_timeout();
    test_done();
  end
endmodule
